// ### verilog/smce_engine.sv
// smbus block read / process call command engine with its bus-side bit engine
`timescale 1ns/10ps
`default_nettype none

module smce_engine #(
	parameter int QTR_CYC = smce_pkg::QTR_CYC_DEF,
	parameter int TO_CYC = smce_pkg::TO_CYC_DEF
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic link_clk_i,
	input wire logic cmd_valid_i,
	input wire smce_pkg::smce_cmd_s cmd_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output smce_pkg::smce_rsp_s rsp_o,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic scl_oe_o,
	output logic sda_o,
	output logic sda_oe_o
);

	localparam int DVW = $clog2(QTR_CYC + 1);
	localparam int TOW = $clog2(TO_CYC + 1);

	// command side, mclk domain
	smce_pkg::smce_cmd_s cmd_q, cmd_d;
	smce_pkg::smce_rsp_s rsp_q, rsp_d;
	logic req_tg_q, req_tg_d;
	logic busy_q, busy_d;
	logic rsp_valid_q, rsp_valid_d;
	logic dn_s1_q, dn_s2_q, dn_s3_q;

	// bus side, link domain
	logic [1:0] lrst_q;
	logic lrst_n;
	logic rq_s1_q, rq_s2_q, rq_s3_q;
	logic scl_s1_q, scl_s_q, sda_s1_q, sda_s_q;
	smce_pkg::smce_ph_e ph_q, ph_d;
	logic [1:0] qtr_q, qtr_d;
	logic [3:0] bit_q, bit_d;
	logic [4:0] idx_q, idx_d;
	logic [7:0] shf_q, shf_d;
	logic [7:0] crc_q, crc_d;
	logic [7:0] err_q, err_d;
	logic [7:0] rcnt_q, rcnt_d;
	logic [DVW-1:0] div_q, div_d;
	logic [TOW-1:0] to_q, to_d;
	logic dn_tg_q, dn_tg_d;
	logic scl_drv_q, scl_drv_d, sda_drv_q, sda_drv_d;
	logic [7:0] mem_q [smce_pkg::MAX_DATA];
	logic mem_we, mem_clr;

	always_comb begin
		cmd_d = cmd_q;
		req_tg_d = req_tg_q;
		busy_d = busy_q;
		rsp_d = rsp_q;
		rsp_valid_d = 1'b0;
		if (busy_q) begin
			if (dn_s2_q != dn_s3_q) begin
				busy_d = 1'b0;
				rsp_d = '0;
				// link side is idle and holds its result until the next request
				if (cmd_q.op != smce_pkg::OP_RESET) begin
					rsp_valid_d = 1'b1;
					rsp_d.err = err_q;
					rsp_d.cnt = rcnt_q;
					for (int i = 0; i < smce_pkg::MAX_DATA; i++) begin
						if (8'(i) < rcnt_q) begin
							rsp_d.data[i] = mem_q[i];
						end
					end
				end
			end
		end else if (cmd_valid_i) begin
			if (cmd_i.op == smce_pkg::OP_PCALL && (cmd_i.cnt < smce_pkg::PCALL_MIN ||
				cmd_i.cnt > smce_pkg::PCALL_MAX || cmd_i.nsup != cmd_i.cnt)) begin
				rsp_d = '0;
				rsp_d.err = smce_pkg::ERR_PARAM;
				rsp_valid_d = 1'b1;
			end else if (cmd_i.op == smce_pkg::OP_BLK_RD || cmd_i.op == smce_pkg::OP_PCALL ||
				cmd_i.op == smce_pkg::OP_RESET) begin
				cmd_d = cmd_i;
				req_tg_d = ~req_tg_q;
				busy_d = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmd_q <= '0;
			rsp_q <= '0;
			req_tg_q <= 1'b0;
			busy_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			dn_s1_q <= 1'b0;
			dn_s2_q <= 1'b0;
			dn_s3_q <= 1'b0;
		end else begin
			cmd_q <= cmd_d;
			rsp_q <= rsp_d;
			req_tg_q <= req_tg_d;
			busy_q <= busy_d;
			rsp_valid_q <= rsp_valid_d;
			dn_s1_q <= dn_tg_q;
			dn_s2_q <= dn_s1_q;
			dn_s3_q <= dn_s2_q;
		end
	end

	assign cmd_ready_o = !busy_q;
	assign rsp_valid_o = rsp_valid_q;
	assign rsp_o = rsp_q;

	// reset release is re-timed so the link side never leaves reset mid-edge
	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lrst_q <= 2'b00;
		end else begin
			lrst_q <= {lrst_q[0], 1'b1};
		end
	end
	assign lrst_n = lrst_q[1];

	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			rq_s1_q <= 1'b0;
			rq_s2_q <= 1'b0;
			rq_s3_q <= 1'b0;
			scl_s1_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			rq_s1_q <= req_tg_q;
			rq_s2_q <= rq_s1_q;
			rq_s3_q <= rq_s2_q;
			scl_s1_q <= scl_i;
			scl_s_q <= scl_s1_q;
			sda_s1_q <= sda_i;
			sda_s_q <= sda_s1_q;
		end
	end

	logic blk, wr_ph, rd_ph, tick, rd_last, txbit;
	logic [7:0] txb, bval, abort, to_code;

	always_comb begin
		ph_d = ph_q;
		qtr_d = qtr_q;
		bit_d = bit_q;
		idx_d = idx_q;
		shf_d = shf_q;
		crc_d = crc_q;
		err_d = err_q;
		rcnt_d = rcnt_q;
		dn_tg_d = dn_tg_q;
		scl_drv_d = scl_drv_q;
		sda_drv_d = sda_drv_q;
		to_d = '0;
		mem_we = 1'b0;
		mem_clr = 1'b0;
		abort = smce_pkg::ERR_NONE;
		blk = cmd_q.op == smce_pkg::OP_BLK_RD;
		tick = div_q == '0;
		div_d = tick ? DVW'(QTR_CYC - 1) : div_q - 1'b1;
		wr_ph = ph_q inside {smce_pkg::PH_AW, smce_pkg::PH_CODE, smce_pkg::PH_WCNT,
			smce_pkg::PH_WDATA, smce_pkg::PH_WPEC, smce_pkg::PH_AR};
		rd_ph = ph_q inside {smce_pkg::PH_RCNT, smce_pkg::PH_RDATA, smce_pkg::PH_RPEC};
		case (ph_q)
			smce_pkg::PH_AW: txb = {cmd_q.addr, smce_pkg::RW_WR};
			smce_pkg::PH_CODE: txb = cmd_q.code;
			smce_pkg::PH_WCNT: txb = cmd_q.cnt;
			smce_pkg::PH_WDATA: txb = cmd_q.data[idx_q];
			smce_pkg::PH_WPEC: txb = crc_q;
			default: txb = {cmd_q.addr, smce_pkg::RW_RD};
		endcase
		txbit = txb[3'(smce_pkg::BIT_MSB - bit_q)];
		case (ph_q)
			smce_pkg::PH_RCNT: rd_last = (shf_q == 8'h00 && !cmd_q.pec) || shf_q > smce_pkg::MAX_RCNT;
			smce_pkg::PH_RDATA: rd_last = {3'b000, idx_q} == rcnt_q - 8'h01 && !cmd_q.pec;
			default: rd_last = 1'b1;
		endcase
		case (ph_q)
			smce_pkg::PH_START: to_code = smce_pkg::ERR_TO_START;
			smce_pkg::PH_RSTART: to_code = smce_pkg::ERR_TO_RSTART;
			smce_pkg::PH_STOP: to_code = smce_pkg::ERR_TO_STOP;
			default: to_code = (rd_ph && bit_q == smce_pkg::ACK_BIT) ? smce_pkg::ERR_TO_ACK : smce_pkg::ERR_TO_READ;
		endcase
		bval = wr_ph ? txb : shf_q;
		if (rq_s2_q != rq_s3_q) begin
			if (cmd_q.op == smce_pkg::OP_RESET) begin
				// soft reset: drop the bus, empty the buffer, restart the 100 khz divider
				ph_d = smce_pkg::PH_IDLE;
				scl_drv_d = 1'b0;
				sda_drv_d = 1'b0;
				rcnt_d = 8'h00;
				err_d = smce_pkg::ERR_NONE;
				mem_clr = 1'b1;
				div_d = DVW'(QTR_CYC - 1);
				dn_tg_d = ~dn_tg_q;
			end else begin
				ph_d = smce_pkg::PH_WAITIDLE;
				qtr_d = smce_pkg::QTR_LOW;
				bit_d = 4'h0;
				idx_d = 5'h00;
				rcnt_d = 8'h00;
				err_d = smce_pkg::ERR_NONE;
			end
		end else begin
			case (ph_q)
				smce_pkg::PH_IDLE: begin
				end
				smce_pkg::PH_WAITIDLE: begin
					if (scl_s_q && sda_s_q) begin
						ph_d = smce_pkg::PH_START;
						qtr_d = smce_pkg::QTR_LOW;
					end else if (to_q == TOW'(TO_CYC - 1)) begin
						abort = smce_pkg::ERR_TO_IDLE;
					end else begin
						to_d = to_q + 1'b1;
					end
				end
				smce_pkg::PH_DONE: begin
					ph_d = smce_pkg::PH_IDLE;
					dn_tg_d = ~dn_tg_q;
				end
				default: begin
					if (qtr_q == smce_pkg::QTR_HIGH && !scl_s_q) begin
						// clock stretch or stuck line: wait, bounded
						if (to_q == TOW'(TO_CYC - 1)) begin
							abort = to_code;
						end else begin
							to_d = to_q + 1'b1;
						end
					end else if (tick) begin
						qtr_d = qtr_q + 2'h1;
						case (qtr_q)
							smce_pkg::QTR_LOW: begin
								scl_drv_d = ph_q != smce_pkg::PH_START;
								if (ph_q == smce_pkg::PH_STOP) begin
									sda_drv_d = 1'b1;
								end else if (wr_ph) begin
									sda_drv_d = bit_q != smce_pkg::ACK_BIT && !txbit;
								end else if (rd_ph) begin
									sda_drv_d = bit_q == smce_pkg::ACK_BIT && !rd_last;
								end else begin
									sda_drv_d = 1'b0;
								end
							end
							smce_pkg::QTR_REL: begin
								scl_drv_d = 1'b0;
							end
							smce_pkg::QTR_HIGH: begin
								if (ph_q == smce_pkg::PH_START || ph_q == smce_pkg::PH_RSTART) begin
									if (!sda_s_q) begin
										abort = smce_pkg::ERR_BCOL;
									end else begin
										sda_drv_d = 1'b1;
									end
								end else if (ph_q == smce_pkg::PH_STOP) begin
									sda_drv_d = 1'b0;
								end else if (wr_ph && bit_q != smce_pkg::ACK_BIT) begin
									if (txbit && !sda_s_q) begin
										abort = smce_pkg::ERR_WCOL;
									end
								end else if (wr_ph) begin
									if (sda_s_q && err_q == smce_pkg::ERR_NONE) begin
										err_d = (ph_q == smce_pkg::PH_AW || ph_q == smce_pkg::PH_AR) ?
											smce_pkg::ERR_ANACK : smce_pkg::ERR_DNACK;
									end
								end else if (bit_q != smce_pkg::ACK_BIT) begin
									shf_d = {shf_q[6:0], sda_s_q};
								end
							end
							default: begin
								scl_drv_d = ph_q != smce_pkg::PH_STOP;
								if (ph_q == smce_pkg::PH_START) begin
									crc_d = smce_pkg::CRC_INIT;
									ph_d = smce_pkg::PH_AW;
								end else if (ph_q == smce_pkg::PH_RSTART) begin
									ph_d = smce_pkg::PH_AR;
								end else if (ph_q == smce_pkg::PH_STOP) begin
									if (!sda_s_q && err_q == smce_pkg::ERR_NONE) begin
										err_d = smce_pkg::ERR_BCOL;
									end
									ph_d = smce_pkg::PH_DONE;
								end else if (bit_q != smce_pkg::ACK_BIT) begin
									bit_d = bit_q + 4'h1;
								end else begin
									bit_d = 4'h0;
									if (ph_q != smce_pkg::PH_WPEC && ph_q != smce_pkg::PH_RPEC) begin
										crc_d = smce_pkg::smce_crc8(crc_q, bval);
									end
									if (err_q != smce_pkg::ERR_NONE) begin
										ph_d = smce_pkg::PH_STOP;
									end else begin
										case (ph_q)
											smce_pkg::PH_AW: ph_d = smce_pkg::PH_CODE;
											smce_pkg::PH_CODE: ph_d = blk ? smce_pkg::PH_RSTART : smce_pkg::PH_WCNT;
											smce_pkg::PH_WCNT: ph_d = smce_pkg::PH_WDATA;
											smce_pkg::PH_WDATA: begin
												if ({3'b000, idx_q} == cmd_q.cnt - 8'h01) begin
													idx_d = 5'h00;
													ph_d = cmd_q.pec ? smce_pkg::PH_WPEC : smce_pkg::PH_RSTART;
												end else begin
													idx_d = idx_q + 5'h01;
												end
											end
											smce_pkg::PH_WPEC: ph_d = smce_pkg::PH_RSTART;
											smce_pkg::PH_AR: ph_d = smce_pkg::PH_RCNT;
											smce_pkg::PH_RCNT: begin
												rcnt_d = shf_q;
												if (shf_q > smce_pkg::MAX_RCNT) begin
													err_d = smce_pkg::ERR_BUF;
													ph_d = smce_pkg::PH_STOP;
												end else if (shf_q == 8'h00) begin
													ph_d = cmd_q.pec ? smce_pkg::PH_RPEC : smce_pkg::PH_STOP;
												end else begin
													ph_d = smce_pkg::PH_RDATA;
												end
											end
											smce_pkg::PH_RDATA: begin
												mem_we = 1'b1;
												if ({3'b000, idx_q} == rcnt_q - 8'h01) begin
													ph_d = cmd_q.pec ? smce_pkg::PH_RPEC : smce_pkg::PH_STOP;
												end else begin
													idx_d = idx_q + 5'h01;
												end
											end
											default: begin
												if (shf_q != crc_q) begin
													err_d = smce_pkg::ERR_CRC;
												end
												ph_d = smce_pkg::PH_STOP;
											end
										endcase
									end
								end
							end
						endcase
					end
				end
			endcase
		end
		// collisions and timeouts leave the bus alone: another master or a stuck line owns it
		if (abort != smce_pkg::ERR_NONE) begin
			if (err_q == smce_pkg::ERR_NONE) begin
				err_d = abort;
			end
			ph_d = smce_pkg::PH_DONE;
			scl_drv_d = 1'b0;
			sda_drv_d = 1'b0;
		end
	end

	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			ph_q <= smce_pkg::PH_IDLE;
			qtr_q <= smce_pkg::QTR_LOW;
			bit_q <= 4'h0;
			idx_q <= 5'h00;
			shf_q <= 8'h00;
			crc_q <= smce_pkg::CRC_INIT;
			err_q <= smce_pkg::ERR_NONE;
			rcnt_q <= 8'h00;
			div_q <= '0;
			to_q <= '0;
			dn_tg_q <= 1'b0;
			scl_drv_q <= 1'b0;
			sda_drv_q <= 1'b0;
		end else begin
			ph_q <= ph_d;
			qtr_q <= qtr_d;
			bit_q <= bit_d;
			idx_q <= idx_d;
			shf_q <= shf_d;
			crc_q <= crc_d;
			err_q <= err_d;
			rcnt_q <= rcnt_d;
			div_q <= div_d;
			to_q <= to_d;
			dn_tg_q <= dn_tg_d;
			scl_drv_q <= scl_drv_d;
			sda_drv_q <= sda_drv_d;
		end
	end

	generate
		for (genvar g = 0; g < smce_pkg::MAX_DATA; g++) begin : g_rx
			always_ff @(posedge link_clk_i or negedge lrst_n) begin
				if (!lrst_n) begin
					mem_q[g] <= 8'h00;
				end else if (mem_clr) begin
					mem_q[g] <= 8'h00;
				end else if (mem_we && idx_q == 5'(g)) begin
					mem_q[g] <= shf_q;
				end
			end
		end
	endgenerate

	// open drain: only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = scl_drv_q;
	assign sda_oe_o = sda_drv_q;

endmodule : smce_engine

`default_nettype wire

// ### verilog/smce_pkg.sv
// constants, types and helpers shared by the command engine
package smce_pkg;

	// command opcodes
	localparam logic [7:0] OP_BLK_RD = 8'h26;
	localparam logic [7:0] OP_PCALL = 8'h27;
	localparam logic [7:0] OP_RESET = 8'hff;

	// answer codes
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_PARAM = 8'h04;
	localparam logic [7:0] ERR_ANACK = 8'h10;
	localparam logic [7:0] ERR_DNACK = 8'h11;
	localparam logic [7:0] ERR_BCOL = 8'h20;
	localparam logic [7:0] ERR_WCOL = 8'h21;
	localparam logic [7:0] ERR_TO_IDLE = 8'h31;
	localparam logic [7:0] ERR_TO_START = 8'h32;
	localparam logic [7:0] ERR_TO_RSTART = 8'h33;
	localparam logic [7:0] ERR_TO_STOP = 8'h34;
	localparam logic [7:0] ERR_TO_READ = 8'h35;
	localparam logic [7:0] ERR_TO_ACK = 8'h36;
	localparam logic [7:0] ERR_BUF = 8'h40;
	localparam logic [7:0] ERR_CRC = 8'h41;

	// sizes and field layout
	localparam int MAX_DATA = 32;
	localparam logic [7:0] MAX_RCNT = 8'h20;
	localparam logic [7:0] PCALL_MIN = 8'h01;
	localparam logic [7:0] PCALL_MAX = 8'h1f;
	localparam logic RW_WR = 1'b0;
	localparam logic RW_RD = 1'b1;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] BIT_MSB = 4'h7;
	localparam logic [1:0] QTR_LOW = 2'h0;
	localparam logic [1:0] QTR_REL = 2'h1;
	localparam logic [1:0] QTR_HIGH = 2'h2;
	localparam logic [1:0] QTR_END = 2'h3;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// timing
	localparam int LINK_HZ = 166_666_667;
	localparam int SCL_RST_HZ = 100_000;
	localparam int TIMEOUT_US = 1000;
	localparam int QTR_CYC_DEF = LINK_HZ / (4 * SCL_RST_HZ);
	localparam int TO_CYC_DEF = (LINK_HZ / 1_000_000) * TIMEOUT_US;

	typedef enum logic [3:0] {
		PH_IDLE, PH_WAITIDLE, PH_START, PH_AW, PH_CODE, PH_WCNT, PH_WDATA, PH_WPEC,
		PH_RSTART, PH_AR, PH_RCNT, PH_RDATA, PH_RPEC, PH_STOP, PH_DONE
	} smce_ph_e;

	typedef struct packed {
		logic [7:0] op;
		logic [6:0] addr;
		logic [7:0] code;
		logic [7:0] cnt;
		logic pec;
		logic [7:0] nsup;
		logic [MAX_DATA-1:0][7:0] data;
	} smce_cmd_s;

	typedef struct packed {
		logic [7:0] err;
		logic [7:0] cnt;
		logic [MAX_DATA-1:0][7:0] data;
	} smce_rsp_s;

	// one byte of the smbus packet error code
	function automatic logic [7:0] smce_crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction : smce_crc8

endpackage : smce_pkg

// ### test/smce_engine_assertions.sv
// port-level checks of the command engine
`timescale 1ns/10ps
`default_nettype none
module smce_engine_chk #(
	parameter int QTR_CYC = 4,
	parameter int TO_CYC = 200
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic link_clk_i,
	input wire logic cmd_valid_i,
	input wire smce_pkg::smce_cmd_s cmd_i,
	input wire logic cmd_ready_o,
	input wire logic rsp_valid_o,
	input wire smce_pkg::smce_rsp_s rsp_o,
	input wire logic scl_oe_o,
	input wire logic sda_oe_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic take;
	assign take = cmd_valid_i && cmd_ready_o;
	AST_PCALL_RANGE: assert property (
		take && cmd_i.op == 8'h27 && (cmd_i.cnt < 8'h01 || cmd_i.cnt > 8'h1f)
		|=> rsp_valid_o && rsp_o.err == 8'h04 && rsp_o.cnt == 8'h00) else $error("write count not refused");
	AST_PCALL_SUPPLY: assert property (
		take && cmd_i.op == 8'h27 && cmd_i.cnt >= 8'h01 && cmd_i.cnt <= 8'h1f && cmd_i.nsup != cmd_i.cnt
		|=> rsp_valid_o && rsp_o.err == 8'h04) else $error("supplied count mismatch not refused");
	AST_PARAM_QUIET: assert property (
		take && cmd_i.op == 8'h27 && cmd_i.cnt == 8'h00 |=> (cmd_ready_o && !scl_oe_o && !sda_oe_o) [*3])
		else $error("refused call touched the bus");
	AST_START_BUSY: assert property (
		take && cmd_i.op == 8'h26 |=> !cmd_ready_o ##1 !cmd_ready_o) else $error("block read not started");
	AST_RSP_PULSE: assert property (
		rsp_valid_o |-> cmd_ready_o ##1 !rsp_valid_o) else $error("answer pulse malformed");
	AST_RSP_COUNT: assert property (
		rsp_valid_o && rsp_o.err == 8'h00 |-> rsp_o.cnt <= 8'h20) else $error("success with oversized count");
	AST_RSP_TAIL: assert property (
		rsp_valid_o && rsp_o.cnt < 8'h20 |-> rsp_o.data[rsp_o.cnt[4:0]] == 8'h00) else $error("data past count");
	AST_RESET_SILENT: assert property (
		take && cmd_i.op == 8'hff |=> !rsp_valid_o [*8]) else $error("reset command answered");
	AST_IDLE_LINES: assert property (
		cmd_ready_o |-> !scl_oe_o && !sda_oe_o) else $error("bus driven while idle");
endmodule : smce_engine_chk
bind smce_engine smce_engine_chk #(.QTR_CYC(QTR_CYC), .TO_CYC(TO_CYC)) chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.link_clk_i(link_clk_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
	.rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o));
`default_nettype wire

// ### test/smce_target.sv
// behavioural bus target answering the engine
`timescale 1ns/10ps
`default_nettype none
module smce_target #(
	parameter logic [6:0] ADDR = 7'h2c
) (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_low_o,
	output logic sda_low_o
);
	logic [7:0] tx [0:39];
	logic [7:0] rx [$];
	logic [7:0] sh;
	int cnt, ti;
	bit act, first, rdm, mnak, nak_d, wcol, stretch, hold_scl, drv;
	assign scl_low_o = hold_scl;
	assign sda_low_o = drv;
	always @(negedge sda_i) if (scl_i === 1'b1) begin
		act = 1;
		first = 1;
		rdm = 0;
		cnt = 0;
	end
	always @(posedge sda_i) if (scl_i === 1'b1) act = 0;
	always @(posedge scl_i) if (act) begin
		if (cnt < 8) begin
			sh = {sh[6:0], sda_i};
			cnt++;
		end else begin
			mnak = sda_i;
			cnt = 0;
		end
	end
	// sda only moves while scl is low, so no false start or stop
	always @(negedge scl_i) if (act) begin
		if (!rdm && cnt == 8) begin
			rx.push_back(sh);
			drv = first ? sh[7:1] == ADDR : !nak_d;
			rdm = first && sh[0];
			first = 0;
		end else if (cnt == 0) begin
			// collision pull only once the address is through, so the address still reaches the target
			drv = rdm ? !mnak && !tx[ti][7] : wcol && !first;
			hold_scl = hold_scl || (stretch && !rdm);
		end else if (rdm) begin
			drv = cnt < 8 && !tx[ti][7 - cnt];
			if (cnt == 8) ti++;
		end
	end
endmodule : smce_target
`default_nettype wire

// ### test/testbench.sv
// self-checking bench: engine against a behavioural target
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic mclk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	smce_pkg::smce_cmd_s cmd_i = '0;
	logic cmd_ready_o, rsp_valid_o, scl_o, scl_oe_o, sda_o, sda_oe_o, t_scl_low, t_sda_low;
	smce_pkg::smce_rsp_s rsp_o;
	wire scl_w, sda_w;
	int miscompares = 0;
	int total_checks = 0;
	logic [7:0] code_v = 8'ha5;
	logic [7:0] sup_skew = 8'h00;
	// pull-ups on both lines
	assign scl_w = !(scl_oe_o || t_scl_low);
	assign sda_w = !(sda_oe_o || t_sda_low);
	smce_engine #(.QTR_CYC(4), .TO_CYC(200)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
		.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
		.scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
	smce_target #(.ADDR(7'h2c)) tgt_u (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(t_scl_low), .sda_low_o(t_sda_low));
	initial forever #20 mclk_i = !mclk_i;
	initial begin
		#7;
		forever #3 link_clk_i = !link_clk_i;
	end
	function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		repeat (8) r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
		return r;
	endfunction : crc
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// target answer: count, pattern bytes, pec (flipped when bad)
	task automatic load(input int n, input logic bad);
		logic [7:0] p;
		p = crc(crc(crc(crc(8'h00, 8'h58), 8'ha5), 8'h59), n[7:0]);
		tgt_u.tx[0] = n[7:0];
		for (int i = 1; i <= n; i++) begin
			tgt_u.tx[i] = 8'h30 + i[7:0];
			p = crc(p, tgt_u.tx[i]);
		end
		tgt_u.tx[n + 1] = p ^ {7'h00, bad};
	endtask : load
	task automatic run(input logic [7:0] op, input logic [6:0] ad, input logic [7:0] cnt, input logic pec);
		int n;
		n = 0;
		tgt_u.rx.delete();
		tgt_u.ti = 0;
		cmd_i.op <= op;
		cmd_i.addr <= ad;
		cmd_i.code <= code_v;
		cmd_i.cnt <= cnt;
		cmd_i.nsup <= cnt - sup_skew;
		cmd_i.pec <= pec;
		cmd_valid_i <= 1'b1;
		@(posedge mclk_i);
		cmd_valid_i <= 1'b0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (rsp_valid_o !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			miscompares++;
			wrap_up();
		end
	endtask : run
	task automatic t_block_read();
		load(3, 1'b0);
		run(8'h26, 7'h2c, 8'h00, 1'b0);
		check("err", rsp_o.err, 8'h00);
		check("count", rsp_o.cnt, 8'h03);
		for (int i = 0; i < 4; i++) check("data", rsp_o.data[i], i < 3 ? 8'h31 + i[7:0] : 8'h00);
		check("addr w", tgt_u.rx[0], 8'h58);
		check("code", tgt_u.rx[1], 8'ha5);
		check("addr r", tgt_u.rx[2], 8'h59);
	endtask : t_block_read
	task automatic t_pec_limits();
		load(32, 1'b0);
		run(8'h26, 7'h2c, 8'h00, 1'b1);
		check("err", rsp_o.err, 8'h00);
		check("last", rsp_o.data[31], 8'h50);
		load(2, 1'b1);
		run(8'h26, 7'h2c, 8'h00, 1'b1);
		check("bad pec", rsp_o.err, 8'h41);
		run(8'h26, 7'h2c, 8'h00, 1'b0);
		check("pec off", rsp_o.err, 8'h00);
		load(33, 1'b0);
		run(8'h26, 7'h2c, 8'h00, 1'b0);
		check("overflow", rsp_o.err, 8'h40);
	endtask : t_pec_limits
	task automatic t_pcall();
		logic [7:0] e [5] = '{8'h58, 8'ha5, 8'h02, 8'h60, 8'h61};
		logic [7:0] p;
		p = 8'h00;
		for (int i = 0; i < 32; i++) cmd_i.data[i] <= 8'h60 + i[7:0];
		load(1, 1'b0);
		run(8'h27, 7'h2c, 8'h02, 1'b1);
		for (int i = 0; i < 5; i++) begin
			check("written", tgt_u.rx[i], e[i]);
			p = crc(p, e[i]);
		end
		check("pec out", tgt_u.rx[5], p);
		check("addr r", tgt_u.rx[6], 8'h59);
		run(8'h27, 7'h2c, 8'h1f, 1'b0);
		check("err", rsp_o.err, 8'h00);
		check("wcount", tgt_u.rx[2], 8'h1f);
		check("last out", tgt_u.rx[33], 8'h7e);
		check("rcount", rsp_o.cnt, 8'h01);
		check("rdata", rsp_o.data[0], 8'h31);
	endtask : t_pcall
	task automatic t_param();
		logic [7:0] cn [3] = '{8'h00, 8'h20, 8'hff};
		foreach (cn[i]) begin
			run(8'h27, 7'h2c, cn[i], 1'b0);
			check("range", rsp_o.err, 8'h04);
			check("quiet", tgt_u.rx.size(), 8'h00);
		end
		sup_skew = 8'h01;
		run(8'h27, 7'h2c, 8'h03, 1'b0);
		check("supply", rsp_o.err, 8'h04);
		sup_skew = 8'h00;
	endtask : t_param
	task automatic t_faults();
		run(8'h26, 7'h13, 8'h00, 1'b0);
		check("addr nack", rsp_o.err, 8'h10);
		tgt_u.nak_d = 1;
		run(8'h26, 7'h2c, 8'h00, 1'b0);
		check("data nack", rsp_o.err, 8'h11);
		tgt_u.nak_d = 0;
		tgt_u.wcol = 1;
		// all-zero command code never sends a one, so the held line first meets the restart
		code_v = 8'h00;
		run(8'h26, 7'h2c, 8'h00, 1'b0);
		check("restart collision", rsp_o.err, 8'h20);
		code_v = 8'ha5;
		tgt_u.drv = 0;
		run(8'h26, 7'h2c, 8'h00, 1'b0);
		check("collision", rsp_o.err, 8'h21);
		tgt_u.wcol = 0;
		tgt_u.drv = 0;
		tgt_u.hold_scl = 1;
		run(8'h26, 7'h2c, 8'h00, 1'b0);
		check("idle timeout", rsp_o.err, 8'h31);
		tgt_u.hold_scl = 0;
		tgt_u.stretch = 1;
		run(8'h26, 7'h2c, 8'h00, 1'b0);
		check("stretch timeout", rsp_o.err, 8'h35);
		tgt_u.stretch = 0;
		tgt_u.hold_scl = 0;
	endtask : t_faults
	task automatic t_reset_op();
		int n;
		n = 0;
		cmd_i.op <= 8'hff;
		cmd_valid_i <= 1'b1;
		@(posedge mclk_i);
		cmd_valid_i <= 1'b0;
		do begin
			@(posedge mclk_i);
			n++;
			check("no answer", {7'h00, rsp_valid_o}, 8'h00);
		end while (cmd_ready_o !== 1'b1 && n < 200);
		check("ready", {7'h00, cmd_ready_o}, 8'h01);
		if (cmd_ready_o !== 1'b1) begin
			wrap_up();
		end
		check("lines", {6'h00, scl_oe_o, sda_oe_o}, 8'h00);
		check("low level", {6'h00, scl_o, sda_o}, 8'h00);
		t_block_read();
	endtask : t_reset_op
	initial begin
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		t_block_read();
		t_pec_limits();
		t_pcall();
		t_param();
		t_faults();
		t_reset_op();
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
